// [core/snvm_pkg.sv]
package snvm_pkg;
    // Serial frame layout
    localparam int CMD_BITS = 4;
    localparam int FRAME_BITS = 20;
    localparam logic [4:0] CNT_CMD_LAST = 5'h03;
    localparam logic [4:0] CNT_IN_LAST = 5'h0B;
    localparam logic [4:0] CNT_FRAME_LAST = 5'h13;
    localparam logic [2:0] OUT_BIT_BIAS = 3'h4;

    // Four-bit commands
    localparam logic [3:0] CMD_CORE = 4'h0;
    localparam logic [3:0] CMD_TBL_RD = 4'h8;
    localparam logic [3:0] CMD_TBL_RD_INC = 4'h9;
    localparam logic [3:0] CMD_TBL_WR_INC2 = 4'hD;
    localparam logic [3:0] CMD_TBL_WR_PROG = 4'hF;

    // Core instruction decode
    localparam logic [7:0] OPC_LOAD_LIT = 8'h0E;
    localparam logic [7:0] OPC_STORE_ACC = 8'h6E;
    localparam logic [3:0] OPC_BIT_SET = 4'h8;
    localparam logic [3:0] OPC_BIT_CLR = 4'h9;

    // Register file addresses seen by core instructions
    localparam logic [7:0] FA_NVM_CONTROL = 8'hA6;
    localparam logic [7:0] FA_PTR_UPPER = 8'hF8;
    localparam logic [7:0] FA_PTR_HIGH = 8'hF7;
    localparam logic [7:0] FA_PTR_LOW = 8'hF6;
    localparam logic [7:0] FA_EE_ADDR_HIGH = 8'hB2;
    localparam logic [7:0] FA_EE_ADDR_LOW = 8'hB1;
    localparam logic [7:0] FA_EE_DATA = 8'hB0;

    // Control register fields
    localparam int CTL_FLASH_SEL = 7;
    localparam int CTL_CFG_SEL = 6;
    localparam int CTL_ROW_ERASE = 4;
    localparam int CTL_WR_EN = 2;
    localparam int CTL_WR_START = 1;
    localparam logic [7:0] CTL_RESET = 8'h00;

    // Memory geometry
    localparam int PTR_W = 22;
    localparam int ROW_IDX_W = 6;
    localparam logic [5:0] ROW_LAST_IDX = 6'h3F;
    localparam logic [21:0] CODE_FIRST = 22'h000000;
    localparam logic [21:0] CODE_LAST = 22'h00FFFF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // Operations handed to the array controller
    localparam int OP_W = 32;
    localparam logic [1:0] OP_ROW_ERASE = 2'h1;
    localparam logic [1:0] OP_PROG_BYTE = 2'h2;
    localparam logic [1:0] OP_EE_WRITE = 2'h3;

    // Commands whose last eight clocks shift a byte out
    function automatic logic snvm_is_read(input logic [3:0] cmd);
        snvm_is_read = (cmd == CMD_TBL_RD) || (cmd == CMD_TBL_RD_INC);
    endfunction : snvm_is_read
endpackage : snvm_pkg

// [core/snvm_op_buf.sv]
`timescale 1ns/100ps
`default_nettype none
module snvm_op_buf
    import snvm_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [OP_W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [OP_W-1:0] out_data_o
);
    logic [OP_W-1:0] head_q, head_d, tail_q, tail_d;
    logic [1:0] cnt_q, cnt_d;
    logic push, pop;

    // Head slot feeds the output straight from a flop
    always_comb begin
        in_ready_o = (cnt_q != 2'h2);
        out_valid_o = (cnt_q != 2'h0);
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        head_d = head_q;
        tail_d = tail_q;
        cnt_d = cnt_q;
        if (push && pop) begin
            if (cnt_q == 2'h1) begin
                head_d = in_data_i;
            end else begin
                head_d = tail_q;
                tail_d = in_data_i;
            end
        end else if (pop) begin
            head_d = tail_q;
            cnt_d = cnt_q - 2'h1;
        end else if (push) begin
            if (cnt_q == 2'h0) begin
                head_d = in_data_i;
            end else begin
                tail_d = in_data_i;
            end
            cnt_d = cnt_q + 2'h1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            head_q <= '0;
            tail_q <= '0;
            cnt_q <= 2'h0;
        end else begin
            head_q <= head_d;
            tail_q <= tail_d;
            cnt_q <= cnt_d;
        end
    end

    assign out_data_o = head_q;
endmodule : snvm_op_buf
`default_nettype wire

// [core/snvm_sequencer.sv]
// Summary of operation
// R1: Erase one 64-byte row on request; refuse it when the row is protected.
// R2: Rows sit on fixed 64-byte boundaries from address zero upward.
// R3: After write-start, the next command's 4th clock held high runs the operation.
// R4: Serial clock falling ends the operation; programmer then keeps it low.
// R5: Any pointer byte inside a row selects the whole row for erase.
// R6: Programmer reads, buffers, modifies, erases and rewrites partial code changes.
// R7: Write-start only takes effect while write-enable is already set.
// R8: Command 1101 buffers two bytes, pointer plus two; 0000 runs a core instruction.
// R9: Command 1111 buffers two bytes and arms programming of the buffered row.
// R10: Programmer sets flash, clears config, sets enable, sets row-erase before erase.
// R11: Programmer sets write-start, sends no-operation 00 00, holds clock high then low.
// R12: Programmer loads the 22-bit pointer one byte at a time via the accumulator.
// R13: Data EEPROM is reached bytewise via a two-byte address and one data latch.
// R14: An EEPROM byte write erases the location itself before writing.
// R15: Programmer clears flash-select and config-select for EEPROM writes.
// R16: Writes of any kind are rejected while write-enable is clear; command 1101 still buffers its two bytes without it;
// a write-start or 1111 arm made before write-enable is cleared still runs its operation.
// R17: Setting write-start begins the EEPROM write sequence.
// R18: EEPROM write begins on the 4th falling clock; hardware then clears write-start.
// R19: Code reads return single bytes; programmer pairs them into words.
// R20: Programmer reloads the pointer for ID space after code verify.
// R21: Post-increment read at the last code address wraps the pointer to zero.
// R22: Command 1001 reads a byte and shifts it out on the data line.
// R23: Bits change on rising clock, sampled on falling clock, LSB first.
// R24: Each frame: 4-bit command then 16-bit operand, 8 in 8 out for reads.
// R25: Programmer waits out both hold times before the next command.
`timescale 1ns/100ps
`default_nettype none
module snvm_sequencer
    import snvm_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic prog_serial_clock_i,
    input wire logic prog_serial_line_i,
    output logic prog_serial_line_o,
    output logic prog_serial_line_oe_o,
    input wire logic row_protected_i,
    output logic [PTR_W-1:0] rd_addr_o,
    input wire logic [7:0] rd_data_i,
    output logic nvm_op_valid_o,
    input wire logic nvm_op_ready_i,
    output logic [1:0] nvm_op_kind_o,
    output logic [PTR_W-1:0] nvm_op_addr_o,
    output logic [7:0] nvm_op_data_o,
    output logic nvm_hv_active_o,
    output logic nvm_refused_o,
    output logic [7:0] nvm_control_o,
    output logic [PTR_W-1:0] table_pointer_o
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PUSH_ONE,
        ST_PUSH_ROW,
        ST_HOLD,
        ST_EE_PUSH
    } snvm_state_t;

    // Pin synchronisers; only the second stage and its delayed copy are decoded
    logic clk_meta_q, clk_sync_q, clk_prev_q, line_meta_q, line_sync_q;
    logic rise, fall;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            clk_meta_q <= 1'b0;
            clk_sync_q <= 1'b0;
            clk_prev_q <= 1'b0;
            line_meta_q <= 1'b0;
            line_sync_q <= 1'b0;
        end else begin
            clk_meta_q <= prog_serial_clock_i;
            clk_sync_q <= clk_meta_q;
            clk_prev_q <= clk_sync_q;
            line_meta_q <= prog_serial_line_i;
            line_sync_q <= line_meta_q;
        end
    end

    assign rise = clk_sync_q && !clk_prev_q;
    assign fall = !clk_sync_q && clk_prev_q;

    snvm_state_t state_q, state_d;
    logic [4:0] cnt_q, cnt_d;
    logic [FRAME_BITS-1:0] frame_q, frame_d;
    logic [3:0] cmd_q, cmd_d;
    logic [7:0] ctl_q, ctl_d, acc_q, acc_d;
    logic [PTR_W-1:0] ptr_q, ptr_d;
    logic [7:0] ee_ah_q, ee_ah_d, ee_al_q, ee_al_d, ee_dat_q, ee_dat_d;
    logic prog_arm_q, prog_arm_d;
    logic out_q, out_d, oe_q, oe_d;
    logic [7:0] obyte_q, obyte_d;
    logic hv_q, hv_d, refused_q, refused_d;
    logic [ROW_IDX_W-1:0] idx_q, idx_d;
    logic [7:0] wbuf_q [0:(1<<ROW_IDX_W)-1];
    logic [7:0] wbuf_d [0:(1<<ROW_IDX_W)-1];
    logic push_v, push_rdy;
    logic [OP_W-1:0] push_w, head_w;
    logic [15:0] opnd;
    logic [ROW_IDX_W-1:0] lo_idx, hi_idx;
    logic trig_armed;

    // Frame shifter, command execution and operation sequencing
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        frame_d = frame_q;
        cmd_d = cmd_q;
        ctl_d = ctl_q;
        acc_d = acc_q;
        ptr_d = ptr_q;
        ee_ah_d = ee_ah_q;
        ee_al_d = ee_al_q;
        ee_dat_d = ee_dat_q;
        prog_arm_d = prog_arm_q;
        out_d = out_q;
        oe_d = oe_q;
        obyte_d = obyte_q;
        hv_d = hv_q;
        refused_d = 1'b0;
        idx_d = idx_q;
        wbuf_d = wbuf_q;
        push_v = 1'b0;
        push_w = '0;
        opnd = '0;
        lo_idx = ptr_q[ROW_IDX_W-1:0];
        hi_idx = ROW_IDX_W'(ptr_q[ROW_IDX_W-1:0] + 6'h01);
        trig_armed = ctl_q[CTL_WR_START] || prog_arm_q;

        // Sample on the falling edge, least significant bit first
        if (fall) begin
            frame_d[cnt_q] = line_sync_q; // R23 R24
            if (cnt_q == CNT_CMD_LAST) begin
                cmd_d = {line_sync_q, frame_q[2:0]};
            end
            if (cnt_q == CNT_IN_LAST && snvm_is_read(cmd_q)) begin
                obyte_d = rd_data_i; // R19 R22
                oe_d = 1'b1;
            end
            if (cnt_q == CNT_FRAME_LAST) begin
                cnt_d = 5'h00;
                oe_d = 1'b0;
                opnd = frame_d[FRAME_BITS-1:CMD_BITS];
                case (cmd_q)
                    CMD_CORE: begin
                        if (opnd[15:8] == OPC_LOAD_LIT) begin // R8
                            acc_d = opnd[7:0];
                        end else if (opnd[15:8] == OPC_STORE_ACC) begin
                            case (opnd[7:0])
                                FA_PTR_UPPER: ptr_d[21:16] = acc_q[5:0];
                                FA_PTR_HIGH: ptr_d[15:8] = acc_q;
                                FA_PTR_LOW: ptr_d[7:0] = acc_q;
                                FA_EE_ADDR_HIGH: ee_ah_d = acc_q; // R13
                                FA_EE_ADDR_LOW: ee_al_d = acc_q;
                                FA_EE_DATA: ee_dat_d = acc_q;
                                default: ;
                            endcase
                        end else if (opnd[7:0] == FA_NVM_CONTROL && opnd[15:12] == OPC_BIT_SET) begin
                            if (opnd[11:9] == 3'(CTL_WR_START)) begin
                                if (ctl_q[CTL_WR_EN]) begin
                                    ctl_d[CTL_WR_START] = 1'b1; // R7 R17
                                end else begin
                                    refused_d = 1'b1; // R16
                                end
                            end else begin
                                ctl_d[opnd[11:9]] = 1'b1;
                            end
                        end else if (opnd[7:0] == FA_NVM_CONTROL && opnd[15:12] == OPC_BIT_CLR) begin
                            ctl_d[opnd[11:9]] = 1'b0;
                        end
                    end
                    CMD_TBL_WR_INC2: begin
                        wbuf_d[lo_idx] = opnd[7:0]; // R8
                        wbuf_d[hi_idx] = opnd[15:8];
                        ptr_d = PTR_W'(ptr_q + 22'h000002);
                    end
                    CMD_TBL_WR_PROG: begin
                        if (ctl_q[CTL_WR_EN]) begin // Refused frame leaves the row buffer alone
                            wbuf_d[lo_idx] = opnd[7:0];
                            wbuf_d[hi_idx] = opnd[15:8];
                            prog_arm_d = 1'b1; // R9
                        end else begin
                            refused_d = 1'b1; // R16
                        end
                    end
                    CMD_TBL_RD_INC: begin
                        // Reads past the code end would land in unimplemented space
                        ptr_d = (ptr_q == CODE_LAST) ? CODE_FIRST : PTR_W'(ptr_q + 22'h000001); // R21
                    end
                    default: ;
                endcase
            end else begin
                cnt_d = cnt_q + 5'h01;
            end
        end

        // Read byte goes out on rising edges 13 to 20; low bits of the count minus four pick the bit
        if (rise && oe_q) begin
            out_d = obyte_q[cnt_q[2:0] - OUT_BIT_BIAS]; // R23 R24
        end

        // Array operations
        case (state_q)
            ST_IDLE: begin
                if (rise && cnt_q == CNT_CMD_LAST && trig_armed && ctl_q[CTL_FLASH_SEL] && !ctl_q[CTL_CFG_SEL]) begin
                    if (row_protected_i) begin
                        refused_d = 1'b1; // R1
                        ctl_d[CTL_WR_START] = 1'b0;
                        prog_arm_d = 1'b0;
                    end else if (prog_arm_q || !ctl_q[CTL_ROW_ERASE]) begin
                        idx_d = '0;
                        hv_d = 1'b1; // R3
                        state_d = ST_PUSH_ROW;
                    end else begin
                        hv_d = 1'b1; // R3
                        state_d = ST_PUSH_ONE;
                    end
                end else if (fall && cnt_q == CNT_CMD_LAST && ctl_q[CTL_WR_START] && !ctl_q[CTL_FLASH_SEL]
                             && !ctl_q[CTL_CFG_SEL]) begin
                    state_d = ST_EE_PUSH; // R18
                end else if (rise && cnt_q == CNT_CMD_LAST && trig_armed && ctl_q[CTL_CFG_SEL]) begin
                    // Configuration writes are not handled by this sequencer
                    refused_d = 1'b1;
                    ctl_d[CTL_WR_START] = 1'b0;
                    prog_arm_d = 1'b0;
                end
            end
            ST_PUSH_ONE: begin
                push_v = 1'b1;
                push_w = {OP_ROW_ERASE, ptr_q[PTR_W-1:ROW_IDX_W], {ROW_IDX_W{1'b0}}, ERASED_BYTE}; // R1 R2 R5
                if (push_rdy) begin
                    state_d = ST_HOLD;
                end
            end
            ST_PUSH_ROW: begin
                push_v = 1'b1;
                push_w = {OP_PROG_BYTE, ptr_q[PTR_W-1:ROW_IDX_W], idx_q, wbuf_q[idx_q]}; // R9
                if (push_rdy) begin
                    wbuf_d[idx_q] = ERASED_BYTE;
                    idx_d = ROW_IDX_W'(idx_q + 6'h01);
                    if (idx_q == ROW_LAST_IDX) begin
                        state_d = ST_HOLD;
                    end
                end
            end
            ST_HOLD: ;
            ST_EE_PUSH: begin
                push_v = 1'b1;
                push_w = {OP_EE_WRITE, 6'h00, ee_ah_q, ee_al_q, ee_dat_q}; // R13 R14
                if (push_rdy) begin
                    ctl_d[CTL_WR_START] = 1'b0; // R18
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase

        // Clock low ends a flash operation, even one cut short mid-row
        if (hv_q && fall) begin
            hv_d = 1'b0; // R4
            ctl_d[CTL_WR_START] = 1'b0;
            prog_arm_d = 1'b0;
            state_d = ST_IDLE;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
            frame_q <= '0;
            cmd_q <= CMD_CORE;
            ctl_q <= CTL_RESET;
            acc_q <= 8'h00;
            ptr_q <= CODE_FIRST;
            ee_ah_q <= 8'h00;
            ee_al_q <= 8'h00;
            ee_dat_q <= 8'h00;
            prog_arm_q <= 1'b0;
            out_q <= 1'b0;
            oe_q <= 1'b0;
            obyte_q <= 8'h00;
            hv_q <= 1'b0;
            refused_q <= 1'b0;
            idx_q <= '0;
            wbuf_q <= '{default: ERASED_BYTE};
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            frame_q <= frame_d;
            cmd_q <= cmd_d;
            ctl_q <= ctl_d;
            acc_q <= acc_d;
            ptr_q <= ptr_d;
            ee_ah_q <= ee_ah_d;
            ee_al_q <= ee_al_d;
            ee_dat_q <= ee_dat_d;
            prog_arm_q <= prog_arm_d;
            out_q <= out_d;
            oe_q <= oe_d;
            obyte_q <= obyte_d;
            hv_q <= hv_d;
            refused_q <= refused_d;
            idx_q <= idx_d;
            wbuf_q <= wbuf_d;
        end
    end

    // Two-entry buffer lets the array controller stall without losing an operation
    snvm_op_buf u_op_buf (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .in_valid_i(push_v),
        .in_ready_o(push_rdy),
        .in_data_i(push_w),
        .out_valid_o(nvm_op_valid_o),
        .out_ready_i(nvm_op_ready_i),
        .out_data_o(head_w)
    );

    assign nvm_op_kind_o = head_w[31:30];
    assign nvm_op_addr_o = head_w[29:8];
    assign nvm_op_data_o = head_w[7:0];
    assign prog_serial_line_o = out_q;
    assign prog_serial_line_oe_o = oe_q;
    assign rd_addr_o = ptr_q;
    assign nvm_hv_active_o = hv_q;
    assign nvm_refused_o = refused_q;
    assign nvm_control_o = ctl_q;
    assign table_pointer_o = ptr_q;
endmodule : snvm_sequencer
`default_nettype wire

// [bench/snvm_seq_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module snvm_seq_checker
    import snvm_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic prog_serial_clock_i,
    input wire logic prog_serial_line_oe_o,
    input wire logic nvm_op_valid_o,
    input wire logic nvm_op_ready_i,
    input wire logic [1:0] nvm_op_kind_o,
    input wire logic [PTR_W-1:0] nvm_op_addr_o,
    input wire logic [7:0] nvm_op_data_o,
    input wire logic nvm_hv_active_o,
    input wire logic nvm_refused_o,
    input wire logic [7:0] nvm_control_o
);
    // Eight serial periods of output plus synchroniser slack
    localparam int OE_MAX = 68;
    logic [7:0] oe_cnt_q, oe_cnt_d;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // Cycles the data line has been driven
    always_comb begin
        oe_cnt_d = prog_serial_line_oe_o ? oe_cnt_q + 8'h01 : 8'h00;
    end
    always_ff @(posedge ref_clk_i) begin
        oe_cnt_q <= rst_i ? 8'h00 : oe_cnt_d;
    end
    // Properties on the sequencer ports
    chk_refuse_pulse: assert property (nvm_refused_o |=> !nvm_refused_o)
        else $error("refusal pulse too long");
    chk_wr_needs_en: assert property ($rose(nvm_control_o[CTL_WR_START]) |-> $past(nvm_control_o[CTL_WR_EN]))
        else $error("write start set without enable");
    chk_erase_row: assert property (nvm_op_valid_o && nvm_op_kind_o == OP_ROW_ERASE |->
        nvm_op_addr_o[5:0] == 6'h00 && nvm_op_data_o == ERASED_BYTE)
        else $error("erase op not row aligned");
    chk_hv_ends: assert property ($fell(prog_serial_clock_i) |-> ##[1:5] !nvm_hv_active_o)
        else $error("high voltage window outlives clock");
    chk_hv_clk_high: assert property ($rose(nvm_hv_active_o) && nvm_control_o[CTL_FLASH_SEL] |->
        prog_serial_clock_i)
        else $error("high voltage window with clock low");
    chk_op_hold: assert property (nvm_op_valid_o && !nvm_op_ready_i |=> nvm_op_valid_o &&
        $stable(nvm_op_kind_o) && $stable(nvm_op_addr_o) && $stable(nvm_op_data_o))
        else $error("stalled op changed");
    chk_oe_window: assert property (oe_cnt_q <= OE_MAX)
        else $error("data line driven too long");
    chk_ee_clears_wr: assert property (nvm_op_valid_o && nvm_op_ready_i && nvm_op_kind_o == OP_EE_WRITE |->
        ##[0:3] !nvm_control_o[CTL_WR_START])
        else $error("write start not cleared");
    cover property (nvm_op_valid_o && nvm_op_kind_o == OP_ROW_ERASE);
    cover property (nvm_op_valid_o && !nvm_op_ready_i && nvm_op_kind_o == OP_PROG_BYTE);
    cover property (nvm_op_valid_o && nvm_op_kind_o == OP_EE_WRITE);
    cover property ($rose(prog_serial_line_oe_o));
endmodule : snvm_seq_checker
bind snvm_sequencer snvm_seq_checker u_chk (.ref_clk_i, .rst_i, .prog_serial_clock_i, .prog_serial_line_oe_o,
    .nvm_op_valid_o, .nvm_op_ready_i, .nvm_op_kind_o, .nvm_op_addr_o, .nvm_op_data_o, .nvm_hv_active_o,
    .nvm_refused_o, .nvm_control_o);
`default_nettype wire

// [bench/snvm_prog_model.sv]
`timescale 1ns/100ps
`default_nettype none
module snvm_prog_model #(
    parameter int HALF = 4,
    parameter int DISCH = 24
) (
    input wire logic ref_clk_i,
    input wire logic line_i,
    output logic sclk_o,
    output logic line_o
);
    // Clock idles low between frames
    initial begin
        sclk_o = 1'b0;
        line_o = 1'b0;
    end
    // One frame, LSB first; hold stretches the 4th high phase, then discharge time low
    task automatic frame(input logic [3:0] cmd, input logic [15:0] pay, input int hold, output logic [7:0] rd);
        logic [19:0] f;
        f = {pay, cmd};
        rd = 8'h00;
        for (int i = 0; i < 20; i++) begin
            @(posedge ref_clk_i);
            sclk_o <= 1'b1;
            // Released line toggles so a stale level never passes
            line_o <= (i >= 12 && cmd[3:1] == 3'b100) ? ~line_o : f[i];
            repeat (HALF + ((i == 3) ? hold : 0)) @(posedge ref_clk_i);
            sclk_o <= 1'b0;
            repeat (HALF - 2 + ((i == 3 && hold > 0) ? DISCH : 0)) @(posedge ref_clk_i);
            if (i >= 12) rd[i - 12] = line_i;
            @(posedge ref_clk_i);
        end
        repeat (2 * HALF) @(posedge ref_clk_i);
    endtask : frame
endmodule : snvm_prog_model
`default_nettype wire

// [bench/serial_nvm_erase_write_verify_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module serial_nvm_erase_write_verify_tb;
    import snvm_pkg::*;
    localparam int HOLD = 400;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic row_prot = 1'b0;
    logic ready = 1'b0;
    logic [7:0] rd_data = 8'h00;
    logic sclk, mline, line_o, line_oe, valid, hv, refused;
    logic [1:0] kind;
    logic [21:0] rd_addr, op_addr, tp, a;
    logic [7:0] op_data, ctl, rb, d;
    logic [5:0] r;
    logic [15:0] p1, p2;
    logic [31:0] ops[$];
    int n_mismatch = 0, check_count = 0, cyc = 0, stall_until = 0, n_ref = 0, n_hv = 0, b;
    wire logic line = line_oe ? line_o : mline;

    initial begin
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    snvm_sequencer dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .prog_serial_clock_i(sclk),
        .prog_serial_line_i(line), .prog_serial_line_o(line_o), .prog_serial_line_oe_o(line_oe),
        .row_protected_i(row_prot), .rd_addr_o(rd_addr), .rd_data_i(rd_data), .nvm_op_valid_o(valid),
        .nvm_op_ready_i(ready), .nvm_op_kind_o(kind), .nvm_op_addr_o(op_addr), .nvm_op_data_o(op_data),
        .nvm_hv_active_o(hv), .nvm_refused_o(refused), .nvm_control_o(ctl), .table_pointer_o(tp));
    snvm_prog_model m (.ref_clk_i(ref_clk_i), .line_i(line), .sclk_o(sclk), .line_o(mline));

    function automatic logic [7:0] exp_rd(input logic [21:0] x);
        return x[7:0] ^ x[15:8] ^ 8'h5A;
    endfunction : exp_rd
    // Byte i of the row after two buffered words at offset r
    function automatic logic [7:0] pbyte(input logic [5:0] i, input logic [5:0] s, input logic [31:0] w);
        logic [5:0] k;
        k = i - s;
        return (i >= s && k < 6'h04) ? w[{k[1:0], 3'b000} +: 8] : ERASED_BYTE;
    endfunction : pbyte

    // Array side: random and forced stalls, code memory read data
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        ready <= (cyc < stall_until) ? 1'b0 : 1'($urandom_range(0, 1));
        rd_data <= exp_rd(rd_addr);
        if (valid === 1'b1 && ready === 1'b1) ops.push_back({kind, op_addr, op_data});
        if (refused === 1'b1) n_ref <= n_ref + 1;
        if (hv === 1'b1) n_hv <= n_hv + 1;
    end

    task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask : check
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results
    task automatic core(input logic [15:0] p);
        m.frame(CMD_CORE, p, 0, rb);
    endtask : core
    task automatic ctlb(input logic s, input logic [2:0] n);
        core({s ? OPC_BIT_SET : OPC_BIT_CLR, n, 1'b0, FA_NVM_CONTROL});
    endtask : ctlb
    task automatic ld(input logic [7:0] fa, input logic [7:0] v);
        core({OPC_LOAD_LIT, v});
        core({OPC_STORE_ACC, fa});
    endtask : ld
    task automatic setp(input logic [21:0] x);
        ld(FA_PTR_UPPER, {2'b00, x[21:16]});
        ld(FA_PTR_HIGH, x[15:8]);
        ld(FA_PTR_LOW, x[7:0]);
    endtask : setp
    // Bounded wait for array operations
    task automatic wait_ops(input int n);
        for (int i = 0; i < 2000 && ops.size() < n; i++) @(posedge ref_clk_i);
        if (ops.size() < n) begin
            n_mismatch++;
            $display("Error op count expected %0d seen %0d", n, ops.size());
            results();
        end
        repeat (20) @(posedge ref_clk_i);
        check("op count", 32'(n), 32'(ops.size()));
    endtask : wait_ops

    initial begin
        void'($urandom(32'h3B9A));
        repeat (3) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        check("control reset", 32'(CTL_RESET), 32'(ctl));
        check("idle outputs", 32'h0, 32'({tp, valid, hv, line_oe}));
        $display("test reset done");
        // Write start and program start refused without enable
        ctlb(1'b1, 3'd1);
        m.frame(CMD_TBL_WR_PROG, 16'h1234, 0, rb);
        check("write start bit", 32'h0, 32'(ctl[CTL_WR_START]));
        check("refusals", 32'd2, 32'(n_ref));
        $display("test refuse done");
        // Plain, incrementing and wrapping reads, then ID space
        a = 22'($urandom_range(0, 32'h0000FFFE));
        for (int c = 0; c < 2; c++) begin
            setp(a);
            m.frame(c ? CMD_TBL_RD_INC : CMD_TBL_RD, 16'h0000, 0, rb);
            check("read byte", 32'(exp_rd(a)), 32'(rb));
            check("read pointer", 32'(a + 22'(c)), 32'(tp));
        end
        setp(CODE_LAST);
        m.frame(CMD_TBL_RD_INC, 16'h0000, 0, rb);
        check("last byte", 32'(exp_rd(CODE_LAST)), 32'(rb));
        check("wrap pointer", 32'(CODE_FIRST), 32'(tp));
        setp(22'h200000);
        m.frame(CMD_TBL_RD, 16'h0, 0, rb);
        check("id byte", 32'(exp_rd(22'h200000)), 32'(rb));
        $display("test read done");
        // Row erase from a pointer inside the row
        ctlb(1'b1, 3'd7);
        ctlb(1'b0, 3'd6);
        a = 22'($urandom_range(0, 32'h0000FFFF));
        setp(a);
        ctlb(1'b1, 3'd2);
        ctlb(1'b1, 3'd4);
        ctlb(1'b1, 3'd1);
        check("write start set", 32'h1, 32'(ctl[CTL_WR_START]));
        b = n_hv;
        m.frame(CMD_CORE, 16'h0000, HOLD, rb);
        wait_ops(1);
        check("erase op", {OP_ROW_ERASE, a & ~22'h3F, ERASED_BYTE}, ops[0]);
        check("hv window", 32'h1, 32'(n_hv > b + 100));
        check("write start end", 32'h0, 32'(ctl[CTL_WR_START]));
        // Same erase on a protected row
        row_prot <= 1'b1;
        b = n_ref;
        ctlb(1'b1, 3'd1);
        m.frame(CMD_CORE, 16'h0000, HOLD, rb);
        wait_ops(1);
        check("protected refusal", 32'(b + 1), 32'(n_ref));
        row_prot <= 1'b0;
        $display("test erase done");
        // Buffer two words, program the row, receiver stalled at first
        ctlb(1'b0, 3'd4);
        r = 6'($urandom_range(0, 29) * 2);
        a = {a[21:6], r};
        p1 = 16'($urandom());
        p2 = 16'($urandom());
        setp(a);
        m.frame(CMD_TBL_WR_INC2, p1, 0, rb);
        check("pointer plus two", 32'(a + 22'd2), 32'(tp));
        m.frame(CMD_TBL_WR_PROG, p2, 0, rb);
        stall_until <= cyc + 40;
        m.frame(CMD_CORE, 16'h0000, HOLD, rb);
        wait_ops(65);
        for (int i = 0; i < 64; i++) check("program op", {OP_PROG_BYTE, a[21:6], 6'(i), pbyte(6'(i), r, {p2, p1})}, ops[1 + i]);
        check("buffer drained", 32'h0, 32'(valid));
        $display("test program done");
        // Data byte write with both selects clear
        ctlb(1'b0, 3'd7);
        ctlb(1'b0, 3'd6);
        d = 8'($urandom());
        ld(FA_EE_ADDR_HIGH, a[15:8]);
        ld(FA_EE_ADDR_LOW, a[7:0]);
        ld(FA_EE_DATA, d);
        ctlb(1'b1, 3'd1);
        m.frame(CMD_CORE, 16'h0000, 0, rb);
        wait_ops(66);
        check("eeprom op", {OP_EE_WRITE, 6'h00, a[15:0], d}, ops[65]);
        check("write start cleared", 32'h0, 32'(ctl[CTL_WR_START]));
        $display("test eeprom done");
        results();
    end
endmodule : serial_nvm_erase_write_verify_tb
`default_nettype wire
